/* rtl/tca_compare_trigger.sv */
// compare outputs, input filters and adc trigger selector
// Contract
// R1: modes 0-5 force, clear, set, toggle, pulse
// R2: pwm1 single point high below compare
// R3: pwm2 is pwm1 with levels reversed
// R4: two point uses a/b window
// R5: 1b phase bit inverts output, slave input
// R6: 1a phase bit inverts output, slave input
// R7: bits 10:8 are 2a mode or filter
// R8: bits 2:0 are 1a mode or filter
// R9: filter 0xx off, else three samples
// R10: nothing triggers adc without bit 7
// R11: bits 1-6 enable channel match triggers
// R12: bit 0 enables update event trigger
// R13: software keeps trigger bits 31:8 default
// R14: trigger control resets to zero
// R15: trigger is one-cycle or of sources
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module tca_compare_trigger
   import tca_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic [15:0] cnt_val,
   input  wire logic        cnt_tick,
   input  wire logic        cnt_down,
   input  wire logic        center_mode,
   input  wire logic        two_point,
   input  wire logic        slave_mode,
   input  wire logic [15:0] ccr_1a,
   input  wire logic [15:0] ccr_1b,
   input  wire logic [15:0] ccr_2a,
   input  wire logic [15:0] ccr_2b,
   input  wire logic        capture_1a,
   input  wire logic        capture_1b,
   input  wire logic        capture_2a,
   input  wire logic        match_3a,
   input  wire logic        match_2b,
   input  wire logic        match_3b,
   input  wire logic        update_event,
   input  wire logic        pin_1a,
   input  wire logic        pin_1b,
   input  wire logic        pin_2a,
   output logic             oc_1a,
   output logic             oc_1b,
   output logic             oc_2a,
   output logic             in_1a,
   output logic             in_1b,
   output logic             in_2a,
   output logic             adc_trigger
);
   tca_main_type     s_q;     // registered state
   tca_main_type     s_d;     // next state
   logic [2:0][15:0] sv;      // single point compare values
   logic [2:0][15:0] wa;      // window low edge
   logic [2:0][15:0] wb;      // window high edge
   logic [2:0]       cap;     // channel captures
   logic [2:0]       hit;     // compare match this cycle
   logic [2:0]       smp;     // filter sample enables
   logic [2:0]       filt;    // filtered inputs
   logic [5:0]       src;     // match sources, trigger bit order
   logic [3:0]       div_en;  // prescaler taps /1 /4 /16 /64

   // per channel operands, 0=1a 1=1b 2=2a
   assign sv  = {ccr_2a, ccr_1b, ccr_1a};
   assign wa  = {ccr_2a, ccr_1a, ccr_1a};
   assign wb  = {ccr_2b, ccr_1b, ccr_1b};
   assign cap = {capture_2a, capture_1b, capture_1a};

   // next reference level for one channel
   function automatic logic ref_next(
      input logic [2:0]  m,
      input logic        r,
      input logic        h,
      input logic [15:0] c,
      input logic [15:0] s,
      input logic [15:0] a,
      input logic [15:0] b
   );
      logic pw;
      logic res;
      pw  = 1'b0;
      res = r;
      case (m)
         TCA_OCM_LOW:  res = 1'b0;                       // R1
         TCA_OCM_HIGH: res = 1'b1;                       // R1
         TCA_OCM_CLR:  res = h ? 1'b0 : r;               // R1
         TCA_OCM_SET:  res = h ? 1'b1 : r;               // R1
         TCA_OCM_TGL:  res = h ? ~r : r;                 // R1
         TCA_OCM_PLS:  res = h | (r & ~cnt_tick);        // R1
         default:
         begin
            if (!two_point)
               pw = cnt_down ? (c <= s) : (c < s);       // R2
            else if (!center_mode)
               pw = (a < c) && (c <= b);                 // R4
            else
               pw = cnt_down ? (c <= b) : (a < c);       // R4
            res = (m == TCA_OCM_PWM2) ? ~pw : pw;        // R3
         end
      endcase
      return res;
   endfunction

   // prescaler taps for the filter sample rate
   always_comb
   begin
      div_en[0] = 1'b1;
      div_en[1] = (s_q.pre & TCA_DIV4_M) == TCA_DIV4_M;
      div_en[2] = (s_q.pre & TCA_DIV16_M) == TCA_DIV16_M;
      div_en[3] = s_q.pre == TCA_DIV64_M;
   end

   // match events and trigger source vector
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         hit[i] = cnt_tick && (cnt_val == sv[i]) && !cap[i];
      end
      // bit order 1a 2a 3a 1b 2b 3b
      src = {match_3b, match_2b, hit[1], match_3a, hit[2], hit[0]};  // R11
   end

   // filters on the shared mode/filter fields
   generate
      for (genvar g = 0; g < 3; g++)
      begin : g_flt
         logic [2:0] fcode;  // filter code, live only in capture
         // field is mode when comparing, filter when capturing
         assign fcode  = cap[g] ? s_q.fltr[g*TCA_CH_STRIDE +: 3] : 3'h0;  // R7 R8
         assign smp[g] = div_en[s_q.fltr[g*TCA_CH_STRIDE +: 2]];  // R9
         tca_filter u_flt (
            .ref_clk (ref_clk),
            .reset_n (reset_n),
            .smp_en  (smp[g]),
            .code    (fcode),
            .din     (s_q.sync2[g]),
            .dout    (filt[g])
         );
      end
   endgenerate

   // next state: bus, sync, compare, trigger
   always_comb
   begin
      s_d       = s_q;
      s_d.sync1 = {pin_2a, pin_1b, pin_1a};
      s_d.sync2 = s_q.sync1;
      s_d.pre   = s_q.pre + 6'h01;
      // register writes, upper trigger bits not stored
      if (reg_wr && reg_addr == TCA_ADDR_TRIG)
         s_d.trig = reg_wdata[7:0];  // R13
      if (reg_wr && reg_addr == TCA_ADDR_FLTR)
         s_d.fltr = reg_wdata[11:0];
      // read data valid the cycle after the strobe only
      s_d.rdata = 32'h0000_0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            TCA_ADDR_TRIG: s_d.rdata = {24'h00_0000, s_q.trig};
            TCA_ADDR_FLTR: s_d.rdata = {20'h0_0000, s_q.fltr};
            default:       s_d.rdata = 32'h0000_0000;  // unmapped
         endcase
      end
      // compare reference and phase per channel
      for (int i = 0; i < 3; i++)
      begin
         if (cap[i])
         begin
            // capture: field is a filter, output parked low
            s_d.refl[i] = 1'b0;  // R7 R8
            s_d.oc[i]   = 1'b0;
         end
         else
         begin
            s_d.refl[i] = ref_next(s_q.fltr[i*TCA_CH_STRIDE +: 3], s_q.refl[i], hit[i],
                                   cnt_val, sv[i], wa[i], wb[i]);  // R7 R8
            s_d.oc[i]   = s_d.refl[i] ^ s_q.fltr[i*TCA_CH_STRIDE+TCA_PH_OFS];  // R5 R6
         end
         // slave mode input polarity from the same phase bit
         s_d.pin[i] = filt[i] ^ (slave_mode & s_q.fltr[i*TCA_CH_STRIDE+TCA_PH_OFS]);  // R5 R6
      end
      // one-cycle trigger, or of enabled sources, gated globally
      s_d.adc = s_q.trig[TCA_TRIG_GLB] &
                ((s_q.trig[TCA_TRIG_UEV] & update_event) |
                 (|(src & s_q.trig[TCA_TRIG_MLO +: 6])));  // R10 R11 R12 R15
   end

   // state register, everything clears at reset
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_q      <= '0;
         s_q.trig <= TCA_TRIG_RST;  // R14
         s_q.fltr <= TCA_FLTR_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign reg_rdata   = s_q.rdata;
   assign oc_1a       = s_q.oc[0];
   assign oc_1b       = s_q.oc[1];
   assign oc_2a       = s_q.oc[2];
   assign in_1a       = s_q.pin[0];
   assign in_1b       = s_q.pin[1];
   assign in_2a       = s_q.pin[2];
   assign adc_trigger = s_q.adc;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_trig_needs_global: assert property (adc_trigger |-> $past(s_q.trig[7])) // R10
      else $error("adc trigger without global enable");

   a_trig_on_update: assert property (s_q.trig[7] && s_q.trig[0] && update_event |=> adc_trigger) // R12
      else $error("update event did not trigger adc");

   a_trig_on_match: assert property (s_q.trig[7] && s_q.trig[1] && hit[0] |=> adc_trigger) // R11
      else $error("channel 1a match did not trigger adc");

   a_trig_no_source: assert property (!update_event && src == 6'h00 |=> !adc_trigger) // R15
      else $error("adc trigger without any source");

   a_trig_readback: assert property (reg_rd && reg_addr == TCA_ADDR_TRIG
                                     |=> reg_rdata == {24'h00_0000, $past(s_q.trig)}) // R14
      else $error("trigger register read back wrong");

   a_force_low: assert property (s_q.fltr[3:0] == 4'h0 && !capture_1a |=> !oc_1a) // R1
      else $error("forced low mode drove 1a high");

   a_force_inverted: assert property (s_q.fltr[7:4] == 4'h9 && !capture_1b |=> !oc_1b) // R5
      else $error("inverted force high did not give low on 1b");

   sequence tgl_hit;
      s_q.fltr[3:0] == 4'h4 && hit[0];
   endsequence
   a_toggle_match: assert property (tgl_hit |=> oc_1a != $past(oc_1a)) // R1
      else $error("toggle mode did not flip 1a on match");

   a_pwm1_up: assert property (s_q.fltr[3:0] == 4'h6 && !two_point && !cnt_down && !capture_1a
                               && cnt_val < ccr_1a |=> oc_1a) // R2
      else $error("pwm1 not high below compare on 1a");

   a_pwm2_up: assert property (s_q.fltr[11:8] == 4'h7 && !two_point && !cnt_down && !capture_2a
                               && cnt_val < ccr_2a |=> !oc_2a) // R3
      else $error("pwm2 not low below compare on 2a");

   a_window_edge: assert property (s_q.fltr[3:0] == 4'h6 && two_point && !center_mode && !capture_1a
                                   && ccr_1a < cnt_val && cnt_val <= ccr_1b |=> oc_1a) // R4
      else $error("edge window not high on 1a");

   a_phase_invert: assert property (s_q.fltr[3] && !capture_1a |=> oc_1a == !s_q.refl[0]) // R6
      else $error("1a phase bit did not invert output");

   a_slave_polarity: assert property (slave_mode && s_q.fltr[3] |=> in_1a == !$past(filt[0])) // R6
      else $error("1a slave input polarity not inverted");
endmodule // tca_compare_trigger

/* inc/tca_pkg.sv */
// shared constants and state types for the compare/adc trigger block
package tca_pkg;
   // register byte offsets
   localparam logic [7:0]  TCA_ADDR_FLTR = 8'h1c;  // output control / input filter
   localparam logic [7:0]  TCA_ADDR_TRIG = 8'h20;  // adc trigger control
   // reset values
   localparam logic [7:0]  TCA_TRIG_RST  = 8'h00;
   localparam logic [11:0] TCA_FLTR_RST  = 12'h000;
   // trigger control fields
   localparam int          TCA_TRIG_GLB  = 7;      // global enable
   localparam int          TCA_TRIG_UEV  = 0;      // update event enable
   localparam int          TCA_TRIG_MLO  = 1;      // lowest match enable bit
   // per channel field layout, channel index 0=1a 1=1b 2=2a
   localparam int          TCA_CH_STRIDE = 4;
   localparam int          TCA_PH_OFS    = 3;
   // compare mode codes
   localparam logic [2:0]  TCA_OCM_LOW   = 3'h0;
   localparam logic [2:0]  TCA_OCM_HIGH  = 3'h1;
   localparam logic [2:0]  TCA_OCM_CLR   = 3'h2;
   localparam logic [2:0]  TCA_OCM_SET   = 3'h3;
   localparam logic [2:0]  TCA_OCM_TGL   = 3'h4;
   localparam logic [2:0]  TCA_OCM_PLS   = 3'h5;
   localparam logic [2:0]  TCA_OCM_PWM1  = 3'h6;
   localparam logic [2:0]  TCA_OCM_PWM2  = 3'h7;
   // filter prescaler masks and run length
   localparam logic [5:0]  TCA_DIV4_M    = 6'h03;
   localparam logic [5:0]  TCA_DIV16_M   = 6'h0f;
   localparam logic [5:0]  TCA_DIV64_M   = 6'h3f;
   localparam logic [1:0]  TCA_FLT_RUN   = 2'h3;

   // top level state
   typedef struct packed {
      logic [7:0]  trig;   // adc trigger control
      logic [11:0] fltr;   // modes, phases, filters
      logic [31:0] rdata;  // read data
      logic [2:0]  refl;   // compare reference levels
      logic [2:0]  oc;     // phased compare outputs
      logic [2:0]  pin;    // polarity adjusted inputs
      logic [2:0]  sync1;  // first sync stage
      logic [2:0]  sync2;  // second sync stage
      logic [5:0]  pre;    // filter prescaler
      logic        adc;    // adc trigger pulse
   } tca_main_type;

   // filter state
   typedef struct packed {
      logic       cand;  // candidate level
      logic [1:0] run;   // equal samples seen
      logic       out;   // filtered level
   } tca_filt_type;
endpackage

/* rtl/tca_filter.sv */
// three sample input filter for one capture channel
`timescale 1ns/10ps
module tca_filter
   import tca_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       smp_en,
   input  wire logic [2:0] code,
   input  wire logic       din,
   output logic            dout
);
   tca_filt_type s_q;  // registered state
   tca_filt_type s_d;  // next state

   // candidate tracking and run counting
   always_comb
   begin
      s_d = s_q;
      if (!code[2])
      begin
         // 0xx passes the sample straight on
         s_d.out  = din;  // R9
         s_d.cand = din;
         s_d.run  = TCA_FLT_RUN;
      end
      else if (smp_en)
      begin
         if (din != s_q.cand)
         begin
            // new level, restart the run
            s_d.cand = din;  // R9
            s_d.run  = 2'h1;
         end
         else if (s_q.run != TCA_FLT_RUN)
         begin
            s_d.run = s_q.run + 2'h1;
         end
         if (din == s_q.cand && s_q.run >= 2'h2)
         begin
            // third equal sample accepted
            s_d.out = din;  // R9
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign dout = s_q.out;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_filter_bypass: assert property (!code[2] |=> dout == $past(din)) // R9
      else $error("filter bypass did not follow input");

   sequence three_equal;
      (smp_en && din == 1'b1 && code[2])[*3];
   endsequence
   a_filter_three: assert property (three_equal |=> dout) // R9
      else $error("filter did not accept three equal samples");
endmodule // tca_filter

/* testbench/tca_adc_model.sv */
// adc start-of-conversion input model fed by the trigger output
`timescale 1ns/10ps
module tca_adc_model
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        soc,
   output logic      [15:0] conv_count
);
   // one conversion per clock that sees the start request high
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         conv_count <= 16'h0000;  // converter idle after reset
      end
      else if (soc)
      begin
         conv_count <= conv_count + 16'h0001;  // start a conversion
      end
   end
endmodule // tca_adc_model

/* testbench/tca_compare_trigger_tb.sv */
// self-checking bench for compare outputs, input filters and adc trigger
`timescale 1ns/10ps
module tca_compare_trigger_tb
   import tca_pkg::*;
;
   typedef struct packed {
      logic [11:0] fltr;  // mode, phase and filter fields
      logic [7:0]  trig;  // trigger enables
      logic [3:0]  ev;    // update, 3a, 2b, 3b
      logic [15:0] cnt;   // counter value at the tick
      logic        adc;   // expected trigger pulse
      logic [2:0]  oc;    // expected 2a, 1b, 1a
   } tca_row_type;
   // stimulus, all valued at time zero
   logic        ref_clk, reset_n;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] cnt_val = 16'h0, ccr_1a = 16'h000a, ccr_1b = 16'h0014, ccr_2a = 16'h001e, ccr_2b = 16'h0028;
   logic        cnt_tick = 1'b0, cnt_down = 1'b0, center_mode = 1'b0, two_point = 1'b0, slave_mode = 1'b0;
   logic        capture_1a = 1'b0, capture_1b = 1'b0, capture_2a = 1'b0;
   logic        match_3a = 1'b0, match_2b = 1'b0, match_3b = 1'b0, update_event = 1'b0;
   logic        pin_1a = 1'b0, pin_1b = 1'b0, pin_2a = 1'b0;
   // observed outputs
   logic [31:0] reg_rdata;
   logic        oc_1a, oc_1b, oc_2a, in_1a, in_1b, in_2a, adc_trigger;
   logic [15:0] conv_count;
   logic [15:0] exp_conv = 16'h0;  // conversions expected so far
   int          n_fail = 0, check_count = 0;
   // ordinary cases, run in order since set/clear/toggle keep state
   tca_row_type rows [21] = '{
      '{12'h000, 8'h81, 4'h8, 16'h0000, 1'b1, 3'b000},
      '{12'h000, 8'h01, 4'h8, 16'h0000, 1'b0, 3'b000},
      '{12'h000, 8'h80, 4'h8, 16'h0000, 1'b0, 3'b000},
      '{12'h000, 8'h88, 4'h4, 16'h0000, 1'b1, 3'b000},
      '{12'h000, 8'ha0, 4'h2, 16'h0000, 1'b1, 3'b000},
      '{12'h000, 8'hc0, 4'h1, 16'h0000, 1'b1, 3'b000},
      '{12'h000, 8'h7f, 4'hf, 16'h000a, 1'b0, 3'b000},
      '{12'h001, 8'h82, 4'h0, 16'h000a, 1'b1, 3'b001},
      '{12'h100, 8'h84, 4'h0, 16'h001e, 1'b1, 3'b100},
      '{12'h010, 8'h90, 4'h0, 16'h0014, 1'b1, 3'b010},
      '{12'h000, 8'h84, 4'h0, 16'h000a, 1'b0, 3'b000},
      '{12'h003, 8'h00, 4'h0, 16'h000a, 1'b0, 3'b001},
      '{12'h002, 8'h00, 4'h0, 16'h000a, 1'b0, 3'b000},
      '{12'h004, 8'h00, 4'h0, 16'h000a, 1'b0, 3'b001},
      '{12'h004, 8'h00, 4'h0, 16'h000a, 1'b0, 3'b000},
      '{12'h005, 8'h00, 4'h0, 16'h000a, 1'b0, 3'b001},
      '{12'h006, 8'h00, 4'h0, 16'h0005, 1'b0, 3'b001},
      '{12'h007, 8'h00, 4'h0, 16'h0005, 1'b0, 3'b000},
      '{12'h00e, 8'h00, 4'h0, 16'h0005, 1'b0, 3'b000},
      '{12'h096, 8'h00, 4'h0, 16'h0005, 1'b0, 3'b001},
      '{12'h006, 8'h00, 4'h0, 16'h000f, 1'b0, 3'b000}};

   tca_compare_trigger i_tca_compare_trigger (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cnt_val(cnt_val),
      .cnt_tick(cnt_tick), .cnt_down(cnt_down), .center_mode(center_mode), .two_point(two_point),
      .slave_mode(slave_mode), .ccr_1a(ccr_1a), .ccr_1b(ccr_1b), .ccr_2a(ccr_2a), .ccr_2b(ccr_2b),
      .capture_1a(capture_1a), .capture_1b(capture_1b), .capture_2a(capture_2a), .match_3a(match_3a),
      .match_2b(match_2b), .match_3b(match_3b), .update_event(update_event), .pin_1a(pin_1a),
      .pin_1b(pin_1b), .pin_2a(pin_2a), .oc_1a(oc_1a), .oc_1b(oc_1b), .oc_2a(oc_2a), .in_1a(in_1a),
      .in_1b(in_1b), .in_2a(in_2a), .adc_trigger(adc_trigger));
   tca_adc_model i_tca_adc_model (.ref_clk(ref_clk), .reset_n(reset_n), .soc(adc_trigger),
      .conv_count(conv_count));

   // 25 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // print verdict and stop
   task automatic give_verdict;
      if (n_fail == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one-cycle write, then an idle cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   // one-cycle read, data looked at in the following cycle only
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, exp);
      @(posedge ref_clk);
   endtask
   // program, fire one event cycle, check pulse, model count and outputs
   task automatic run_row(input tca_row_type r);
      wr(TCA_ADDR_FLTR, {20'h0, r.fltr});
      wr(TCA_ADDR_TRIG, {24'h0, r.trig});
      cnt_val <= r.cnt;
      cnt_tick <= 1'b1;
      {update_event, match_3a, match_2b, match_3b} <= r.ev;
      @(posedge ref_clk);
      cnt_tick <= 1'b0;
      {update_event, match_3a, match_2b, match_3b} <= 4'h0;
      exp_conv = exp_conv + 16'(r.adc);
      @(negedge ref_clk);
      chk(adc_trigger, r.adc);
      @(negedge ref_clk);
      chk(adc_trigger, 1'b0);
      @(negedge ref_clk);
      chk({oc_2a, oc_1b, oc_1a}, r.oc);
      chk(conv_count, exp_conv);
      @(posedge ref_clk);
   endtask

   // watchdog, far beyond the expected run length
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      n_fail++;
      give_verdict;
   end

   // main sequence
   initial
   begin
      reset_n = 1'b0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rd(TCA_ADDR_TRIG, 32'h0);
      rd(TCA_ADDR_FLTR, 32'h0);
      wr(TCA_ADDR_TRIG, 32'h0000_00ff);
      rd(TCA_ADDR_TRIG, 32'h0000_00ff);
      rd(8'h04, 32'h0);
      foreach (rows[i])
         run_row(rows[i]);
      // window compare, then single point counting down
      two_point <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(oc_1a, 1'b1);
      // center aligned window: high above a counting up, high up to b counting down
      @(posedge ref_clk);
      center_mode <= 1'b1;
      cnt_val <= 16'h0019;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(oc_1a, 1'b1);
      @(posedge ref_clk);
      cnt_down <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(oc_1a, 1'b0);
      @(posedge ref_clk);
      center_mode <= 1'b0;
      two_point <= 1'b0;
      cnt_down <= 1'b1;
      cnt_val <= 16'h000a;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(oc_1a, 1'b1);
      // back-to-back update events give back-to-back pulses
      @(posedge ref_clk);
      wr(TCA_ADDR_TRIG, 32'h0000_0081);
      update_event <= 1'b1;
      exp_conv = exp_conv + 16'h0003;
      for (int k = 0; k < 3; k++)
      begin
         @(posedge ref_clk);
         update_event <= (k < 2);
         @(negedge ref_clk);
         chk(adc_trigger, 1'b1);
      end
      @(negedge ref_clk);
      chk(adc_trigger, 1'b0);
      chk(conv_count, exp_conv);
      // filter code 100 swallows a one-cycle glitch
      @(posedge ref_clk);
      wr(TCA_ADDR_FLTR, 32'h0000_0004);
      capture_1a <= 1'b1;
      pin_1a <= 1'b1;
      @(posedge ref_clk);
      pin_1a <= 1'b0;
      repeat (10) @(negedge ref_clk) chk(in_1a, 1'b0);
      @(posedge ref_clk);
      pin_1a <= 1'b1;
      for (int k = 0; k < 12 && in_1a !== 1'b1; k++)
         @(negedge ref_clk);
      chk(in_1a, 1'b1);
      // code 101 samples every fourth clock, so a change takes far longer
      @(posedge ref_clk);
      wr(TCA_ADDR_FLTR, 32'h0000_0005);
      pin_1a <= 1'b0;
      repeat (10) @(negedge ref_clk) chk(in_1a, 1'b1);
      for (int k = 0; k < 12 && in_1a !== 1'b0; k++)
         @(negedge ref_clk);
      chk(in_1a, 1'b0);
      // bypass filters, slave input polarity from the phase bits
      @(posedge ref_clk);
      wr(TCA_ADDR_FLTR, 32'h0000_0088);
      pin_1a <= 1'b1;
      slave_mode <= 1'b1;
      capture_1b <= 1'b1;
      capture_2a <= 1'b1;
      pin_2a <= 1'b1;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({in_2a, in_1b, in_1a}, 3'b110);
      // reset in mid-run clears the enables and blocks the trigger
      @(posedge ref_clk);
      wr(TCA_ADDR_TRIG, 32'h0000_0081);
      reset_n <= 1'b0;
      update_event <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      // event still present at the first edge out of reset
      @(posedge ref_clk);
      update_event <= 1'b0;
      @(negedge ref_clk);
      chk(adc_trigger, 1'b0);
      @(posedge ref_clk);
      rd(TCA_ADDR_TRIG, 32'h0);
      give_verdict;
   end
endmodule // tca_compare_trigger_tb
